// file: hw/irq_resp_pkg.sv
// Shared types and constants for the interrupt response timing block.
package irq_resp_pkg;

  // ==========================================================================
  // Status word fields seen from the core.
  // ==========================================================================
  typedef struct packed {
    logic       block_bit;             // One holds off exception handling.
    logic [3:0] interrupt_mask_level;  // Requests must exceed this level.
  } cpu_status_word_t;

  // Request sources; NMI first, then level or on-chip by the higher level, a tie to the level.
  typedef enum logic [1:0] {
    SRC_NONE  = 2'h0,
    SRC_NMI   = 2'h1,
    SRC_LEVEL = 2'h2,
    SRC_PERI  = 2'h3
  } src_t;

  // Sequencer states; Gray codes along idle, decide, wait, handler.
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_DECIDE  = 2'h1,
    ST_WAIT    = 2'h3,
    ST_HANDLER = 2'h2
  } state_t;

  // ==========================================================================
  // Timing and addressing constants.
  // ==========================================================================
  localparam logic [31:0] HANDLER_OFFSET      = 32'h0000_0600;
  localparam logic [7:0]  HANDLER_FETCH_CYC   = 8'h05;  // Core cycles, save to fetch.
  localparam logic [7:0]  LOAD_STATUS_EXEC_CYC = 8'h07; // Longest instruction on a hit.
  localparam logic [4:0]  NMI_LEVEL           = 5'h10;  // Above any maskable level.
  localparam logic [3:0]  LEVEL_NONE          = 4'h0;   // Encoded level meaning no request.
  // Decision times in half core cycles: fixed core part plus clock multiples.
  localparam int          DEC_CORE_HALF       = 1;
  localparam int          DEC_NMI_BUS_HALF    = 1;
  localparam int          DEC_NMI_PER_HALF    = 1;
  localparam int          DEC_LVL_BUS_HALF    = 1;
  localparam int          DEC_LVL_PER_HALF    = 4;
  localparam int          DEC_PERI_PER_HALF   = 3;

endpackage : irq_resp_pkg

// file: hw/irq_resp_timing.sv
// Interrupt decision, deferral and exception entry timing for the core.
`timescale 1ns/1ps
// Overview of operation
// - Block bit set holds requests until cleared.
// - Decision time depends on source clock mix.
// - Wait for running instruction, at most S-1.
// - Block set by instruction or exception defers.
// - Handler fetch starts five cycles after save.
// - Status load takes seven plus external waits.
// - Forward only levels above the mask level.
// - Handler address is vector base plus offset.
module irq_resp_timing #(
  parameter int BUS_DIV = 1,   // Core cycles per external bus clock period.
  parameter int PER_DIV = 1    // Core cycles per peripheral clock period.
) (
  input  wire logic                           ref_clk,
  input  wire logic                           nrst,
  input  wire logic                           nmi_req,
  input  wire logic [3:0]                     encoded_level_request,
  input  wire logic                           peri_req,
  input  wire logic [3:0]                     peri_level,
  input  wire irq_resp_pkg::cpu_status_word_t cpu_status_word,
  input  wire logic [31:0]                    vector_base,
  input  wire logic                           exec_start,
  input  wire logic [7:0]                     exec_states,
  input  wire logic                           exec_is_load_status,
  input  wire logic [7:0]                     exec_ext_wait,
  output logic                                cpu_irq,
  output logic                                instr_end,
  output logic                                exc_start,
  output logic                                fetch_start,
  output logic [31:0]                         fetch_addr,
  output irq_resp_pkg::src_t                  accepted_src
);
  import irq_resp_pkg::*;

  // ==========================================================================
  // Decision delays, rounded up to whole core cycles.
  // ==========================================================================
  localparam int  NMI_HALF  = DEC_CORE_HALF + DEC_NMI_BUS_HALF * BUS_DIV
                              + DEC_NMI_PER_HALF * PER_DIV;
  localparam int  LVL_HALF  = DEC_CORE_HALF + DEC_LVL_BUS_HALF * BUS_DIV
                              + DEC_LVL_PER_HALF * PER_DIV;
  localparam int  PERI_HALF = DEC_CORE_HALF + DEC_PERI_PER_HALF * PER_DIV;
  localparam logic [7:0] NMI_DEC_CYC  = 8'((NMI_HALF + 1) / 2);
  localparam logic [7:0] LVL_DEC_CYC  = 8'((LVL_HALF + 1) / 2);
  localparam logic [7:0] PERI_DEC_CYC = 8'((PERI_HALF + 1) / 2);

  // ==========================================================================
  // State.
  // ==========================================================================
  state_t      state;        // Sequencer state.
  state_t      next_state;   // Sequencer next state.
  logic [7:0]  dec_cnt;      // Cycles left in the priority decision.
  logic [7:0]  fetch_cnt;    // Cycles left before the handler fetch.
  logic [7:0]  exec_cnt;     // Cycles left in the running instruction.
  logic        block_hold;   // Block set by our own exception entry.
  src_t        cand_src;     // Source chosen when the decision began.

  // ==========================================================================
  // Source selection and mask comparison.
  // ==========================================================================
  wire         lvl_req   = (encoded_level_request != LEVEL_NONE);
  wire         any_req   = nmi_req | lvl_req | peri_req;
  wire         lvl_wins  = lvl_req & (!peri_req | (encoded_level_request >= peri_level));
  wire src_t   sel_src   = nmi_req  ? SRC_NMI :
                           lvl_wins ? SRC_LEVEL :
                           peri_req ? SRC_PERI : SRC_NONE;
  wire [4:0]   sel_level = (cand_src == SRC_NMI)   ? NMI_LEVEL :
                           (cand_src == SRC_LEVEL) ? {1'b0, encoded_level_request} :
                           (cand_src == SRC_PERI)  ? {1'b0, peri_level} : 5'h00;
  // Strictly greater than the mask; equal levels stay pending.
  wire         above_mask = sel_level > {1'b0, cpu_status_word.interrupt_mask_level};
  wire [7:0]   sel_dec_cyc = (sel_src == SRC_NMI)   ? NMI_DEC_CYC :
                             (sel_src == SRC_LEVEL) ? LVL_DEC_CYC : PERI_DEC_CYC;

  // ==========================================================================
  // Instruction length and boundary.
  // ==========================================================================
  // The status load is charged its fixed count plus the external waits.
  wire [7:0]   start_len = exec_is_load_status ? 8'(LOAD_STATUS_EXEC_CYC + exec_ext_wait)
                                               : exec_states;
  wire         at_end    = (exec_cnt == 8'h01);
  // The live block bit may lag our own entry, so both are honoured.
  wire         blocked   = cpu_status_word.block_bit | block_hold;
  wire         take_now  = (state == ST_WAIT) & at_end & !blocked;
  wire         dec_done  = (state == ST_DECIDE) & (dec_cnt == 8'h01);

  // Next-state logic for the entry sequence.
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:    if (any_req) next_state = ST_DECIDE;
      ST_DECIDE:  if (dec_done) next_state = above_mask ? ST_WAIT : ST_IDLE;
      ST_WAIT:    if (take_now) next_state = ST_HANDLER;
                  else if (!above_mask) next_state = ST_IDLE;
      ST_HANDLER: if (fetch_cnt == 8'h01) next_state = ST_IDLE;
    endcase
  end

  // Sequencer state and decision counter.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state    <= ST_IDLE;
      dec_cnt  <= 8'h00;
      cand_src <= SRC_NONE;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE && any_req)
      begin
        dec_cnt  <= sel_dec_cyc;
        cand_src <= sel_src;
      end
      else if (dec_cnt != 8'h00)
        dec_cnt <= dec_cnt - 8'h01;
    end
  end

  // Running-instruction counter; a new start reloads it.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      exec_cnt <= 8'h00;
    else if (exec_start)
      exec_cnt <= start_len;
    else if (exec_cnt != 8'h00)
      exec_cnt <= exec_cnt - 8'h01;
  end

  // Own block flag: set by entry, released at an end outside the handler state with the bit clear.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      block_hold <= 1'b0;
    else if (take_now)
      block_hold <= 1'b1;
    else if (at_end && !cpu_status_word.block_bit && state != ST_HANDLER)
      block_hold <= 1'b0;
  end

  // Handler fetch countdown from the status and counter save.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      fetch_cnt <= 8'h00;
    else if (take_now)
      fetch_cnt <= HANDLER_FETCH_CYC;
    else if (fetch_cnt != 8'h00)
      fetch_cnt <= fetch_cnt - 8'h01;
  end

  // ==========================================================================
  // Registered outputs.
  // ==========================================================================
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cpu_irq      <= 1'b0;
      instr_end    <= 1'b0;
      exc_start    <= 1'b0;
      fetch_start  <= 1'b0;
      fetch_addr   <= 32'h0000_0000;
      accepted_src <= SRC_NONE;
    end
    else
    begin
      instr_end   <= at_end;
      exc_start   <= take_now;
      fetch_start <= (state == ST_HANDLER) & (fetch_cnt == 8'h01);
      cpu_irq     <= (next_state == ST_WAIT);
      if (take_now)
      begin
        accepted_src <= cand_src;
        fetch_addr   <= vector_base + HANDLER_OFFSET;
      end
    end
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  // Longest unblocked wait: the instruction counter cannot hold more than this.
  localparam int WAIT_MAX = 255;

  property p_block_holds;
    @(posedge ref_clk) disable iff (!nrst) cpu_status_word.block_bit |=> !exc_start;
  endproperty
  a_block_holds: assert property (p_block_holds) else $error("entry while blocked");

  property p_decide_nmi;
    @(posedge ref_clk) disable iff (!nrst)
      (state == ST_IDLE && nmi_req) |=> (dec_cnt == NMI_DEC_CYC);
  endproperty
  a_decide_nmi: assert property (p_decide_nmi) else $error("wrong nmi decision time");

  property p_decide_len;
    @(posedge ref_clk) disable iff (!nrst)
      (state == ST_IDLE && any_req && !nmi_req && lvl_wins) |=> (dec_cnt == LVL_DEC_CYC);
  endproperty
  a_decide_len: assert property (p_decide_len) else $error("wrong level decision time");

  property p_wait_bound;
    @(posedge ref_clk) disable iff (!nrst)
      (state == ST_WAIT && !blocked && exec_cnt != 8'h00) |-> ##[1:WAIT_MAX] exc_start;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("wait overran instruction");

  property p_entry_at_break;
    @(posedge ref_clk) disable iff (!nrst) exc_start |-> instr_end;
  endproperty
  a_entry_at_break: assert property (p_entry_at_break) else $error("entry off a break");

  property p_no_reentry;
    @(posedge ref_clk) disable iff (!nrst) exc_start |=> !exc_start [*5];
  endproperty
  a_no_reentry: assert property (p_no_reentry) else $error("entry not deferred");

  property p_fetch_five;
    @(posedge ref_clk) disable iff (!nrst) exc_start |-> ##5 fetch_start;
  endproperty
  a_fetch_five: assert property (p_fetch_five) else $error("fetch not five cycles on");

  property p_load_len;
    @(posedge ref_clk) disable iff (!nrst)
      (exec_start && exec_is_load_status && exec_ext_wait == 8'h00)
      ##1 !exec_start [*7] |-> ##1 instr_end;
  endproperty
  a_load_len: assert property (p_load_len) else $error("status load length wrong");

  property p_mask_cmp;
    @(posedge ref_clk) disable iff (!nrst)
      (dec_done && !above_mask) |=> !cpu_irq;
  endproperty
  a_mask_cmp: assert property (p_mask_cmp) else $error("masked request forwarded");

  property p_vector;
    @(posedge ref_clk) disable iff (!nrst)
      take_now |=> (fetch_addr == $past(vector_base) + HANDLER_OFFSET);
  endproperty
  a_vector: assert property (p_vector) else $error("bad handler address");

  c_nmi_entry:  cover property (@(posedge ref_clk) disable iff (!nrst)
                                exc_start && cand_src == SRC_NMI);
  c_lvl_entry:  cover property (@(posedge ref_clk) disable iff (!nrst)
                                exc_start && cand_src == SRC_LEVEL);
  c_peri_entry: cover property (@(posedge ref_clk) disable iff (!nrst)
                                exc_start && cand_src == SRC_PERI);
  c_deferred:   cover property (@(posedge ref_clk) disable iff (!nrst)
                                state == ST_WAIT && at_end && blocked);

endmodule : irq_resp_timing

// file: bench/core_model.sv
// Behavioural model of the core pipeline that issues instructions and owns the status word.
`timescale 1ns/1ps
module core_model
  import irq_resp_pkg::*;
(
  input  wire logic                           ref_clk,
  input  wire logic                           nrst,
  input  wire logic                           instr_end,
  input  wire logic                           exc_start,
  input  wire logic [3:0]                     mask_level,
  input  wire logic                           rte,
  input  wire logic [7:0]                     s_len,
  input  wire logic                           load_en,
  input  wire logic [7:0]                     ext_wait,
  output logic                                exec_start,
  output logic [7:0]                          exec_states,
  output logic                                exec_is_load_status,
  output logic [7:0]                          exec_ext_wait,
  output irq_resp_pkg::cpu_status_word_t      cpu_status_word
);
  logic started;  // Set once the first instruction has gone out.
  logic block_flag;  // Block bit as the core holds it.
  wire  issue = instr_end | ~started;  // A new instruction starts after each end.

  // ==========================================================================
  // Instruction issue
  // ==========================================================================
  // Issue back to back so every break is usable; the fields stay put until the
  // next issue, so they still describe the instruction that just ended.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      started         <= 1'b0;
      exec_start      <= 1'b0;
      exec_states     <= 8'h01;
      exec_is_load_status <= 1'b0;
      exec_ext_wait   <= 8'h00;
    end
    else
    begin
      started    <= 1'b1;
      exec_start <= issue;
      if (issue)
      begin
        exec_states     <= s_len;
        exec_is_load_status <= load_en;
        exec_ext_wait   <= ext_wait;
      end
    end
  end

  // ==========================================================================
  // Status word
  // ==========================================================================
  // Entry sets the block bit one cycle after exc_start, behind the block's own hold; only a handler
  // return clears it, which lets the bench hold interrupts off at will.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      block_flag <= 1'b0;
    else if (exc_start)
      block_flag <= 1'b1;
    else if (rte)
      block_flag <= 1'b0;
  end

  assign cpu_status_word = {block_flag, mask_level};  // The mask level comes from the bench.
endmodule : core_model

// file: bench/tb_top.sv
// Self-checking testbench for the interrupt response timing block.
`timescale 1ns/1ps
module tb_top;
  import irq_resp_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  typedef struct packed {
    src_t        src;   // Source that should win.
    logic [31:0] addr;  // Handler entry address expected.
  } exp_t;
  logic             ref_clk, nrst, nmi_req, peri_req, rte, load_en;
  logic [3:0]       encoded_level_request, peri_level, mask_level;
  logic [7:0]       s_len, ext_wait, exec_states, exec_ext_wait;
  logic [31:0]      vector_base, fetch_addr;
  logic             exec_start, exec_is_load_status, cpu_irq, instr_end, exc_start, fetch_start;
  src_t             accepted_src;
  cpu_status_word_t cpu_status_word;
  exp_t             exp_q[$];  // Expected entries, oldest first.
  exp_t             e;
  int               n_fail, check_count, n_entry;
  logic [31:0]      cyc, ent_cyc, end_cyc;

  irq_resp_timing uut (.ref_clk(ref_clk), .nrst(nrst), .nmi_req(nmi_req),
    .encoded_level_request(encoded_level_request), .peri_req(peri_req),
    .peri_level(peri_level), .cpu_status_word(cpu_status_word), .vector_base(vector_base),
    .exec_start(exec_start), .exec_states(exec_states),
    .exec_is_load_status(exec_is_load_status),
    .exec_ext_wait(exec_ext_wait), .cpu_irq(cpu_irq), .instr_end(instr_end),
    .exc_start(exc_start), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
    .accepted_src(accepted_src));
  core_model core (.ref_clk(ref_clk), .nrst(nrst), .instr_end(instr_end),
    .exc_start(exc_start), .mask_level(mask_level), .rte(rte), .s_len(s_len),
    .load_en(load_en), .ext_wait(ext_wait), .exec_start(exec_start),
    .exec_states(exec_states), .exec_is_load_status(exec_is_load_status),
    .exec_ext_wait(exec_ext_wait), .cpu_status_word(cpu_status_word));

  // ==========================================================================
  // Clock, random lengths and the hang limit
  // ==========================================================================
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Instruction lengths and wait counts change every cycle to vary the break.
  always @(posedge ref_clk)
  begin
    s_len    <= 8'($urandom_range(1, 8));
    ext_wait <= 8'($urandom_range(0, 7));
    cyc      <= cyc + 32'h0000_0001;
    if (cyc == 32'h0000_1388)
    begin
      n_fail++;
      test_done();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Notes one entry, waits for it under a bound, then clears the sources.
  task automatic serve(input src_t src, input logic ret);
    int          n0;
    int          t;
    logic [31:0] vb;
    @(posedge ref_clk);
    n0 = n_entry;
    t  = 0;
    vb = $urandom();
    vector_base <= vb;
    exp_q.push_back('{src, vb + HANDLER_OFFSET});
    while (n_entry == n0 && t < 200)
    begin
      @(posedge ref_clk);
      t++;
    end
    chk("entry seen", 32'h0000_0001, {31'h0, n_entry != n0});
    nmi_req               <= 1'b0;
    peri_req              <= 1'b0;
    encoded_level_request <= 4'h0;
    repeat (8) @(posedge ref_clk);
    rte <= ret;
    @(posedge ref_clk);
    rte <= 1'b0;
  endtask : serve

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // ==========================================================================
  // Monitor: entries, handler fetch delay and instruction lengths
  // ==========================================================================
  always @(negedge ref_clk)
  begin
    if (exc_start === 1'b1)
    begin
      ent_cyc = cyc;
      n_entry++;
      if (exp_q.size() == 0)
        chk("unexpected entry", 32'h0000_0000, 32'h0000_0001);
      else
      begin
        e = exp_q.pop_front();
        chk("accepted_src", {30'h0, e.src}, {30'h0, accepted_src});
        chk("fetch_addr", e.addr, fetch_addr);
      end
    end
    if (fetch_start === 1'b1)
      chk("fetch delay", 32'h0000_0005, cyc - ent_cyc);
    if (instr_end === 1'b1)
    begin
      // The core issues one cycle after each end and the count loads one cycle later.
      if (end_cyc != 32'h0000_0000)
        chk("instr length", 32'h0000_0002 + (exec_is_load_status ?
          {24'h0, LOAD_STATUS_EXEC_CYC} + {24'h0, exec_ext_wait} : {24'h0, exec_states}),
          cyc - end_cyc);
      end_cyc = cyc;
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    {nrst, nmi_req, peri_req, rte, load_en} = 5'h00;
    {encoded_level_request, peri_level, mask_level} = 12'h000;
    {s_len, ext_wait, vector_base} = {8'h01, 8'h00, 32'h0000_0000};
    {cyc, ent_cyc, end_cyc} = {32'h0, 32'h0, 32'h0};
    void'($urandom(32'hb8b5));
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    // The non-maskable source wins even with the mask at its top.
    mask_level <= 4'hf;
    encoded_level_request <= 4'h3;
    nmi_req <= 1'b1;
    serve(SRC_NMI, 1'b1);
    $display("test nmi done");
    // Every level one step above the mask is taken.
    for (int lv = 1; lv < 16; lv++)
    begin
      mask_level <= 4'(lv - 1);
      encoded_level_request <= 4'(lv);
      serve(SRC_LEVEL, 1'b1);
    end
    // A level equal to the mask is never forwarded.
    mask_level <= 4'h9;
    encoded_level_request <= 4'h9;
    repeat (30) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("cpu_irq at mask", 32'h0000_0000, {31'h0, cpu_irq});
    @(posedge ref_clk);
    // Drop the masked level and let a decision in flight lapse, since the
    // source is fixed when a decision begins.
    encoded_level_request <= 4'h0;
    repeat (4) @(posedge ref_clk);
    $display("test levels done");
    // A higher on-chip request beats the encoded level; a tie goes to the level.
    mask_level <= 4'h2;
    encoded_level_request <= 4'ha;
    peri_level <= 4'hc;
    peri_req <= 1'b1;
    serve(SRC_PERI, 1'b1);
    encoded_level_request <= 4'h7;
    peri_level <= 4'h7;
    peri_req <= 1'b1;
    serve(SRC_LEVEL, 1'b0);
    // With the block bit left set, a new request waits until it is cleared.
    nmi_req <= 1'b1;
    repeat (40) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("cpu_irq blocked", 32'h0000_0001, {31'h0, cpu_irq});
    @(posedge ref_clk);
    rte <= 1'b1;
    serve(SRC_NMI, 1'b1);
    $display("test block done");
    // Status loads with random wait counts.
    load_en <= 1'b1;
    repeat (120) @(posedge ref_clk);
    load_en <= 1'b0;
    $display("test status load done");
    test_done();
  end
endmodule : tb_top
